// [shared/ccd_regs.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH

// ==========================================================================
// Register indices; the byte address on the bus is four times the index.
`define CCD_TRIM_IDX 10'h096
`define CCD_CDIV_IDX 10'h095
`define CCD_AUX1_IDX 10'h0A2
`define CCD_STAT_IDX 10'h0A3

// ==========================================================================
// Field positions.
`define CCD_TRIM_LSB 0
`define CCD_TRIM_MSB 5
`define CCD_CLKOUT_BIT 6
`define CCD_RCSEL_BIT 7
`define CCD_LOWPWR_BIT 7

// ==========================================================================
// Reset values.
`define CCD_TRIM_TOP_RST 2'h0
`define CCD_CDIV_RST 8'h00
`define CCD_AUX1_RST 8'h00

// ==========================================================================
// Bus responses.
`define CCD_RESP_OKAY 2'h0
`define CCD_RESP_SLVERR 2'h2

// ==========================================================================
// Wake-up timing: oscillator cycles, then a fixed interval on aclk.
`define CCD_WAKE_XTAL_CYC 10'h3E0
`define CCD_WAKE_RC_CYC 10'h0E0
`define CCD_CLK_PERIOD_NS 20
`define CCD_WAKE_EXTRA_NS 60000
`define CCD_WAKE_EXTRA_CYC \
  12'((`CCD_WAKE_EXTRA_NS + `CCD_CLK_PERIOD_NS - 1) / `CCD_CLK_PERIOD_NS)

`endif

// [shared/ccd_pkg.sv]
// Types shared by the clock select and divide block.
`default_nettype none

package ccd_pkg;

  // ========================================================================
  // Oscillator source chosen by the configuration strap.
  typedef enum logic [2:0] {
    CCD_SRC_XTAL_LOW,
    CCD_SRC_XTAL_MED,
    CCD_SRC_XTAL_HIGH,
    CCD_SRC_RC,
    CCD_SRC_WDOG,
    CCD_SRC_EXT
  } ccd_src_e;

  // ========================================================================
  // Wake-up sequencer states.
  typedef enum logic [1:0] {
    CCD_WK_OSC,
    CCD_WK_TIME,
    CCD_WK_RUN
  } ccd_wake_e;

  // ========================================================================
  // Register select after address decode.
  typedef enum logic [2:0] {
    CCD_SEL_TRIM,
    CCD_SEL_CDIV,
    CCD_SEL_AUX1,
    CCD_SEL_STAT,
    CCD_SEL_NONE
  } ccd_sel_e;

  // True for any of the three crystal selections.
  function automatic logic ccd_is_xtal(input ccd_src_e src);
    ccd_is_xtal = (src == CCD_SRC_XTAL_LOW) || (src == CCD_SRC_XTAL_MED) ||
                  (src == CCD_SRC_XTAL_HIGH);
  endfunction

endpackage

`default_nettype wire

// [shared/ccd_clk_if.sv]
// Signals between the clock controller and its divider.
`timescale 1ns/1ps
`default_nettype none

interface ccd_clk_if;
  logic osc_tick;
  logic run;
  logic [7:0] divider;
  logic cpu_tick;

  modport div (input osc_tick, input run, input divider, output cpu_tick);
  modport ctl (output osc_tick, output run, output divider, input cpu_tick);
endinterface

`default_nettype wire

// [rtl/ccd_divider.sv]
// Oscillator tick divider producing the CPU clock enable.
`timescale 1ns/1ps
`default_nettype none

module ccd_divider (
  input wire logic aclk,
  input wire logic aresetn,
  ccd_clk_if.div clk_if
);

  logic [8:0] cnt_r;
  logic [8:0] limit;

  // Period is twice a nonzero divider value in oscillator ticks; a divider of 0 gives one tick.
  assign limit = {clk_if.divider, 1'b0} - 9'h001;

  // ========================================================================
  // Divider counter.
  // A counter beyond a freshly lowered limit wraps at once, so a new divider
  // value takes effect without a stall or a long gap.
  always_ff @(posedge aclk) begin
    if (!aresetn || !clk_if.run) begin
      cnt_r <= 9'h000;
      clk_if.cpu_tick <= 1'b0;
    end else if (clk_if.osc_tick) begin
      if (clk_if.divider == 8'h00) begin
        cnt_r <= 9'h000;
        clk_if.cpu_tick <= 1'b1;
      end else if (cnt_r >= limit) begin
        cnt_r <= 9'h000;
        clk_if.cpu_tick <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 9'h001;
        clk_if.cpu_tick <= 1'b0;
      end
    end else begin
      clk_if.cpu_tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [rtl/ccd_top.sv]
// Clock select, wake-up delay and CPU clock divider with register access.
`include "ccd_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ccd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] clock_source_sel,
  input wire logic [5:0] factory_trim,
  input wire logic crystal_tick,
  input wire logic rc_tick,
  input wire logic wdog_tick,
  input wire logic crystal_input_pin_tick,
  input wire logic power_down,
  input wire logic port_three_bit_zero_level,
  input wire logic port_three_bit_zero_enable,
  output logic cpu_clock_en,
  output logic periph_clock_en,
  output logic cpu_clock_ready,
  output logic [5:0] rc_trim,
  output logic low_power_clock,
  output logic crystal_output_pin_o,
  output logic crystal_output_pin_oe
);

  // ========================================================================
  // Address decode shared by the read and write paths.
  function automatic ccd_pkg::ccd_sel_e ccd_decode(input logic [11:0] addr);
    if (addr == {`CCD_TRIM_IDX, 2'h0}) begin
      ccd_decode = ccd_pkg::CCD_SEL_TRIM;
    end else if (addr == {`CCD_CDIV_IDX, 2'h0}) begin
      ccd_decode = ccd_pkg::CCD_SEL_CDIV;
    end else if (addr == {`CCD_AUX1_IDX, 2'h0}) begin
      ccd_decode = ccd_pkg::CCD_SEL_AUX1;
    end else if (addr == {`CCD_STAT_IDX, 2'h0}) begin
      ccd_decode = ccd_pkg::CCD_SEL_STAT;
    end else begin
      ccd_decode = ccd_pkg::CCD_SEL_NONE;
    end
  endfunction

  ccd_clk_if clk_if ();

  ccd_pkg::ccd_src_e src_r;
  ccd_pkg::ccd_wake_e wake_r;
  logic [7:0] trim_r;
  logic [7:0] cdiv_r;
  logic [7:0] aux1_r;
  logic [9:0] osc_cnt_r;
  logic [11:0] time_cnt_r;
  logic ready_r;
  logic pclk_phase_r;
  logic periph_en_r;
  logic clkout_r;
  logic pin_o_r;
  logic pin_oe_r;
  logic awready_r;
  logic wready_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic osc_tick_sel;
  logic xtal_in_use;
  logic [9:0] wake_limit;
  logic wr_fire;
  ccd_pkg::ccd_sel_e wr_sel;
  ccd_pkg::ccd_sel_e rd_sel;

  // ========================================================================
  // Oscillator source selection.
  // The RC select bit overrides the strapped source on the fly; the tick
  // inputs are enables already aligned to aclk, so no glitch can occur.
  always_comb begin
    if (trim_r[`CCD_RCSEL_BIT]) begin
      osc_tick_sel = rc_tick;
    end else begin
      case (src_r)
        ccd_pkg::CCD_SRC_XTAL_LOW: osc_tick_sel = crystal_tick;
        ccd_pkg::CCD_SRC_XTAL_MED: osc_tick_sel = crystal_tick;
        ccd_pkg::CCD_SRC_XTAL_HIGH: osc_tick_sel = crystal_tick;
        ccd_pkg::CCD_SRC_RC: osc_tick_sel = rc_tick;
        ccd_pkg::CCD_SRC_WDOG: osc_tick_sel = wdog_tick;
        ccd_pkg::CCD_SRC_EXT: osc_tick_sel = crystal_input_pin_tick;
        default: osc_tick_sel = rc_tick;
      endcase
    end
  end

  // The crystal counts as in use only while it feeds the CPU clock.
  assign xtal_in_use = ccd_pkg::ccd_is_xtal(src_r) &&
                       !trim_r[`CCD_RCSEL_BIT];

  // Wake length follows the source in effect.
  assign wake_limit = xtal_in_use ? `CCD_WAKE_XTAL_CYC
                                  : `CCD_WAKE_RC_CYC;

  // ========================================================================
  // Source strap, caught while reset is held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      case (clock_source_sel)
        3'h0: src_r <= ccd_pkg::CCD_SRC_XTAL_LOW;
        3'h1: src_r <= ccd_pkg::CCD_SRC_XTAL_MED;
        3'h2: src_r <= ccd_pkg::CCD_SRC_XTAL_HIGH;
        3'h3: src_r <= ccd_pkg::CCD_SRC_RC;
        3'h4: src_r <= ccd_pkg::CCD_SRC_WDOG;
        3'h5: src_r <= ccd_pkg::CCD_SRC_EXT;
        default: src_r <= ccd_pkg::CCD_SRC_RC;
      endcase
    end
  end

  // ========================================================================
  // Wake-up sequencer: oscillator cycles, then a fixed settling interval.
  // Only the 60 us lower bound is waited; the upper bound is a tolerance.
  always_ff @(posedge aclk) begin
    if (!aresetn || power_down) begin
      wake_r <= ccd_pkg::CCD_WK_OSC;
      osc_cnt_r <= 10'h000;
      time_cnt_r <= 12'h000;
    end else begin
      case (wake_r)
        ccd_pkg::CCD_WK_OSC: begin
          if (osc_tick_sel) begin
            if (osc_cnt_r == wake_limit - 10'h001) begin
              wake_r <= ccd_pkg::CCD_WK_TIME;
              osc_cnt_r <= 10'h000;
            end else begin
              osc_cnt_r <= osc_cnt_r + 10'h001;
            end
          end
        end
        ccd_pkg::CCD_WK_TIME: begin
          if (time_cnt_r == `CCD_WAKE_EXTRA_CYC - 12'h001) begin
            wake_r <= ccd_pkg::CCD_WK_RUN;
          end else begin
            time_cnt_r <= time_cnt_r + 12'h001;
          end
        end
        ccd_pkg::CCD_WK_RUN: begin
          wake_r <= ccd_pkg::CCD_WK_RUN;
        end
        default: begin
          wake_r <= ccd_pkg::CCD_WK_OSC;
        end
      endcase
    end
  end

  // Gate for the divider; the CPU clock stays off until wake-up ends.
  always_ff @(posedge aclk) begin
    if (!aresetn || power_down) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (wake_r == ccd_pkg::CCD_WK_RUN);
    end
  end

  // ========================================================================
  // Divider hookup.
  assign clk_if.osc_tick = osc_tick_sel;
  // Power-down stops the divider at the same edge that drops ready, so no
  // CPU clock pulse escapes while ready is already low.
  assign clk_if.run = ready_r && !power_down;
  assign clk_if.divider = cdiv_r;

  ccd_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_if(clk_if)
  );

  // ========================================================================
  // Peripheral clock: every second CPU clock, which is one machine cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_phase_r <= 1'b0;
      periph_en_r <= 1'b0;
    end else begin
      periph_en_r <= clk_if.cpu_tick && pclk_phase_r;
      if (clk_if.cpu_tick) begin
        pclk_phase_r <= !pclk_phase_r;
      end
    end
  end

  // ========================================================================
  // Crystal output pin: clock output, ordinary port bit, or left to the
  // crystal amplifier while the crystal is running the CPU.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clkout_r <= 1'b0;
      pin_o_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else if (trim_r[`CCD_CLKOUT_BIT] && !xtal_in_use) begin
      if (clk_if.cpu_tick) begin
        clkout_r <= !clkout_r;
      end
      pin_o_r <= clkout_r;
      pin_oe_r <= 1'b1;
    end else if (!xtal_in_use) begin
      clkout_r <= 1'b0;
      pin_o_r <= port_three_bit_zero_level;
      pin_oe_r <= port_three_bit_zero_enable;
    end else begin
      clkout_r <= 1'b0;
      pin_o_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end
  end

  // ========================================================================
  // Write address and data channels, taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_addr_r <= s_axi_awaddr;
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end
      if (bvalid_r && s_axi_bready) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_sel = ccd_decode(aw_addr_r);

  // Write response, one cycle after both halves are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `CCD_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_sel == ccd_pkg::CCD_SEL_NONE) ? `CCD_RESP_SLVERR
                                                    : `CCD_RESP_OKAY;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ========================================================================
  // Trim register. Any reset reloads calibration; software may rewrite all
  // eight bits, so it must merge the low six itself.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_r <= {`CCD_TRIM_TOP_RST, factory_trim};
    end else if (wr_fire && wr_sel == ccd_pkg::CCD_SEL_TRIM && w_strb_r[0]) begin
      trim_r <= w_data_r[7:0];
    end
  end

  // Divider value; any value from 0 to 255 is legal at any time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cdiv_r <= `CCD_CDIV_RST;
    end else if (wr_fire && wr_sel == ccd_pkg::CCD_SEL_CDIV && w_strb_r[0]) begin
      cdiv_r <= w_data_r[7:0];
    end
  end

  // Auxiliary control: only the low-power clock bit is implemented.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux1_r <= `CCD_AUX1_RST;
    end else if (wr_fire && wr_sel == ccd_pkg::CCD_SEL_AUX1 && w_strb_r[0]) begin
      aux1_r[`CCD_LOWPWR_BIT] <= w_data_r[`CCD_LOWPWR_BIT];
    end
  end

  // ========================================================================
  // Read channel; the answer comes the cycle after the address is taken.
  assign rd_sel = ccd_decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `CCD_RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= `CCD_RESP_OKAY;
      case (rd_sel)
        ccd_pkg::CCD_SEL_TRIM: rdata_r <= {24'h000000, trim_r};
        ccd_pkg::CCD_SEL_CDIV: rdata_r <= {24'h000000, cdiv_r};
        ccd_pkg::CCD_SEL_AUX1: rdata_r <= {24'h000000, aux1_r};
        ccd_pkg::CCD_SEL_STAT: begin
          rdata_r <= {27'h0000000, pin_oe_r && trim_r[`CCD_CLKOUT_BIT],
                      3'(src_r), ready_r};
        end
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= `CCD_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ========================================================================
  // Port drivers, each straight from a flip-flop.
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign cpu_clock_en = clk_if.cpu_tick;
  assign periph_clock_en = periph_en_r;
  assign cpu_clock_ready = ready_r;
  assign rc_trim = trim_r[`CCD_TRIM_MSB:`CCD_TRIM_LSB];
  assign low_power_clock = aux1_r[`CCD_LOWPWR_BIT];
  assign crystal_output_pin_o = pin_o_r;
  assign crystal_output_pin_oe = pin_oe_r;

endmodule

`default_nettype wire

// [test/ccd_top_chk.sv]
// Port-level assertions for the clock select and divide block.
`timescale 1ns/1ps
`default_nettype none

module ccd_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] factory_trim,
  input wire logic power_down,
  input wire logic cpu_clock_en,
  input wire logic periph_clock_en,
  input wire logic cpu_clock_ready,
  input wire logic [5:0] rc_trim,
  input wire logic low_power_clock,
  input wire logic crystal_output_pin_o,
  input wire logic crystal_output_pin_oe
);
  // A little below the shortest wake-up so edge alignment never trips it.
  localparam int WAKE_MIN = 3220;
  int wait_cnt;
  default clocking cb @(posedge aclk); endclocking

  // =========================================================================
  // Cycles spent waiting since reset or power-down was last released.
  always_ff @(posedge aclk) begin
    if (!aresetn || power_down || cpu_clock_ready) begin
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end

  // =========================================================================
  // Assertions.
  a_reset_clears: assert property (
    !aresetn |=> !cpu_clock_ready && !cpu_clock_en && !low_power_clock)
    else $error("reset left clock outputs active");
  a_trim_loads: assert property (
    !aresetn |=> rc_trim == $past(factory_trim))
    else $error("trim not loaded from calibration at reset");
  a_gated_clock: assert property (
    disable iff (!aresetn) cpu_clock_en |-> cpu_clock_ready)
    else $error("cpu clock pulse before wake-up done");
  a_periph_spaced: assert property (
    disable iff (!aresetn) periph_clock_en |=> !periph_clock_en)
    else $error("peripheral pulse on two cycles in a row");
  a_down_stops: assert property (
    disable iff (!aresetn) $rose(power_down) |-> ##[1:2] !cpu_clock_ready)
    else $error("power down did not drop ready");
  a_wake_floor: assert property (
    disable iff (!aresetn) $rose(cpu_clock_ready) |-> wait_cnt >= WAKE_MIN)
    else $error("wake-up delay too short");
  a_bresp_holds: assert property (disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_holds: assert property (disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_write_answer: assert property (disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");

  c_ready: cover property ($rose(cpu_clock_ready));
  c_periph: cover property (periph_clock_en);
  c_pin: cover property (crystal_output_pin_oe && $changed(crystal_output_pin_o));
endmodule

bind ccd_top ccd_top_chk ccd_top_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .factory_trim(factory_trim), .power_down(power_down),
  .cpu_clock_en(cpu_clock_en), .periph_clock_en(periph_clock_en),
  .cpu_clock_ready(cpu_clock_ready), .rc_trim(rc_trim),
  .low_power_clock(low_power_clock),
  .crystal_output_pin_o(crystal_output_pin_o),
  .crystal_output_pin_oe(crystal_output_pin_oe));

`default_nettype wire

// [test/ccd_top_test.sv]
// Self-checking bench for the clock select and divide block.
`include "ccd_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ccd_top_test;
  localparam logic [11:0] A_TRIM = 12'(`CCD_TRIM_IDX * 4);
  localparam logic [11:0] A_CDIV = 12'(`CCD_CDIV_IDX * 4);
  localparam logic [11:0] A_AUX1 = 12'(`CCD_AUX1_IDX * 4);
  localparam logic [11:0] A_STAT = 12'(`CCD_STAT_IDX * 4);
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, tick_on, power_down;
  logic port_lvl, port_en, cpu_clock_en, periph_clock_en, cpu_clock_ready;
  logic low_power_clock, pin_o, pin_oe;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, r;
  logic [31:0] seed = 32'h0000_8A2E;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] src;
  logic [5:0] ft, factory_trim, rc_trim;
  logic [7:0] dv [6];
  logic [2:0] srcs [4] = '{3'h4, 3'h5, 3'h3, 3'h0};
  int mismatches, compares, cycles, n, k, lo;

  ccd_top ccd_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .clock_source_sel(src),
    .factory_trim(factory_trim), .crystal_tick(tick_on), .rc_tick(tick_on),
    .wdog_tick(tick_on), .crystal_input_pin_tick(tick_on),
    .power_down(power_down), .port_three_bit_zero_level(port_lvl),
    .port_three_bit_zero_enable(port_en), .cpu_clock_en(cpu_clock_en),
    .periph_clock_en(periph_clock_en), .cpu_clock_ready(cpu_clock_ready),
    .rc_trim(rc_trim), .low_power_clock(low_power_clock),
    .crystal_output_pin_o(pin_o), .crystal_output_pin_oe(pin_oe));

  // =========================================================================
  // Clock, and a cycle ceiling well above the roughly 27000 cycles needed.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Xorshift source; a fixed start keeps every run identical.
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // =========================================================================
  // Comparison, verdict and bus tasks.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Each task waits an edge first so no signal is driven twice at one edge.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Spacing of pulses; the first two gaps may straddle a divider change.
  task automatic gap(input bit p, output int g);
    for (int i = 0; i < 3; i++) begin
      g = 0;
      do begin
        @(posedge aclk);
        g++;
      end while ((p ? periph_clock_en : cpu_clock_en) !== 1'b1 && g < 2000);
    end
  endtask

  task automatic wait_ready(output int g);
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (cpu_clock_ready !== 1'b1 && g < 8000);
  endtask

  task automatic do_reset(input logic [2:0] s);
    r = rnd();
    ft = r[5:0];
    @(posedge aclk);
    src <= s;
    factory_trim <= ft;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // =========================================================================
  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 4'h0;
    {s_axi_arvalid, s_axi_rready, power_down, port_lvl, port_en} <= 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 56'h0;
    {s_axi_wstrb, tick_on, src, factory_trim} <= {4'hF, 1'b1, 3'h3, 6'h00};
    for (int i = 0; i < 4; i++) begin
      do_reset(srcs[i]);
      wait_ready(n);
      lo = (srcs[i] == 3'h0) ? 992 + 3000 : 224 + 3000;
      check("wake cycles", n >= lo && n <= lo + 8, 1);
      axi_read(A_TRIM);
      check("trim reset", rd, {26'h0, ft});
      check("low power pin", low_power_clock, 1'b0);
      axi_write(A_AUX1, 32'h0000_0080);
      axi_read(A_AUX1);
      check("aux one", rd, 32'h0000_0080);
      check("low power set", low_power_clock, 1'b1);
      $display("test wake and reset source %0d done", srcs[i]);
    end
    // Crystal source: clock out only once the RC select bit is set.
    axi_read(A_TRIM);
    axi_write(A_TRIM, rd | 32'h40);
    repeat (4) @(posedge aclk);
    check("pin oe crystal", pin_oe, 1'b0);
    axi_write(A_TRIM, rd | 32'hC0);
    repeat (4) @(posedge aclk);
    check("pin oe rc select", pin_oe, 1'b1);
    $display("test crystal clock out done");
    do_reset(3'h3);
    wait_ready(n);
    axi_write(12'h100, rnd());
    check("unmapped wr", rsp, `CCD_RESP_SLVERR);
    axi_read(12'h100);
    check("unmapped rresp", rsp, `CCD_RESP_SLVERR);
    check("unmapped rd", rd, 32'h0);
    axi_read(A_STAT);
    check("status", rd[4:0], 5'h07);
    repeat (4) begin
      r = rnd();
      axi_write(A_TRIM, {24'h0, r[7:0]});
      axi_read(A_TRIM);
      check("trim rw", rd, {24'h0, r[7:0]});
      check("trim out", rc_trim, r[5:0]);
    end
    $display("test registers done");
    r = rnd();
    dv = '{8'h00, 8'h01, 8'h02, 8'hFF, r[7:0], r[15:8]};
    foreach (dv[i]) begin
      axi_write(A_CDIV, {24'h0, dv[i]});
      axi_read(A_CDIV);
      check("divider rw", rd, {24'h0, dv[i]});
      lo = (dv[i] == 8'h00) ? 1 : 2 * dv[i];
      gap(1'b0, n);
      check("cpu period", n, lo);
      gap(1'b1, n);
      check("periph period", n, 2 * lo);
    end
    $display("test divider done");
    axi_write(A_CDIV, 32'h1);
    axi_read(A_TRIM);
    axi_write(A_TRIM, (rd & 32'h3F) | 32'h40);
    repeat (4) @(posedge aclk);
    check("clkout oe", pin_oe, 1'b1);
    k = 0;
    repeat (40) begin
      lo = pin_o;
      @(posedge aclk);
      k += (pin_o !== lo);
    end
    check("clkout toggles", k >= 19 && k <= 21, 1);
    axi_write(A_TRIM, rd & 32'h3F);
    r = rnd();
    port_en <= 1'b1;
    port_lvl <= r[0];
    repeat (4) @(posedge aclk);
    check("port pin", {pin_oe, pin_o}, {1'b1, r[0]});
    port_en <= 1'b0;
    repeat (4) @(posedge aclk);
    check("port pin off", pin_oe, 1'b0);
    $display("test clock out done");
    power_down <= 1'b1;
    repeat (4) @(posedge aclk);
    check("ready in power down", cpu_clock_ready, 1'b0);
    power_down <= 1'b0;
    wait_ready(n);
    check("wake after down", n >= 3224 && n <= 3232, 1);
    $display("test power down done");
    give_verdict();
  end
endmodule

`default_nettype wire
